// file: verilog/rxo_output_loop_ctrl.sv
// Purpose: Receive output formatting, muting on signal loss and loopback selection
// Assumes: recClk runs at twice the line bit rate; rxDecoded and txEncoded are on recClk
// Notes:   Configuration crosses as quasi-static levels; change it only while idle
`timescale 1ns/1ps
`include "rxo_consts.svh"
module rxo_output_loop_ctrl (
   // System clock and reset
   input  wire logic              clock,
   input  wire logic              rst_n,
   // Register port from the serial host interface
   input  wire logic [7:0]        regAddr,
   input  wire logic              regWrEn,
   input  wire rxo_pkg::rxo_reg_t regWrData,
   input  wire logic              regRdEn,
   output rxo_pkg::rxo_reg_t      regRdData,
   // Strap pins
   input  wire logic              hostMode,
   input  wire logic              muteEnablePin,
   input  wire logic              clockBInvertPin,
   input  wire logic              localLoopbackPin,
   input  wire logic              remoteLoopbackPin,
   input  wire logic              transmitDriverOffPin,
   input  wire logic              e3ModePin,
   // Status
   output logic                   signalAbsentFlag,
   // Link side
   input  wire logic              recClk,
   input  wire rxo_pkg::rxo_rail_t rxDecoded,
   input  wire rxo_pkg::rxo_rail_t txEncoded,
   input  wire logic              amplitudeDropout,
   input  wire logic              zeroRunDropout,
   // Terminal outputs
   output logic                   rxPlusRailOut,
   output logic                   rxMinusRailOut,
   output logic                   recoveredClockA,
   output logic                   recoveredClockB,
   // Toward the line driver
   output rxo_pkg::rxo_rail_t     lineTx
);
   import rxo_pkg::*;

   // System domain state
   rxo_outctl_t outCtl_q;
   rxo_loopctl_t loopCtl_q;
   rxo_reg_t    regRdData_q;
   logic        signalAbsent_q;
   logic [6:0]  pinS;
   logic        hostS;
   rxo_cfg_t    cfgS;
   logic [2:0]  statS;

   // Link domain state
   logic        linkRstN;
   rxo_cfg_t    cfgL;
   logic [1:0]  dropL;
   logic        phase_q;
   logic        lossL_q;
   logic        rxPlus_q;
   logic        rxMinus_q;
   logic        recClkA_q;
   logic        recClkB_q;
   rxo_rail_t   lineTx_q;
   rxo_rail_t   source;
   logic        lossRaw;
   logic        upd;
   logic        muteNow;

   // Pins come from outside the clock domain
   rxo_sync #(.W(7)) pinSync (
      .clock (clock),
      .d     ({hostMode, muteEnablePin, clockBInvertPin, localLoopbackPin,
               remoteLoopbackPin, transmitDriverOffPin, e3ModePin}),
      .q     (pinS)
   );
   assign hostS = pinS[6];

   // Register writes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         outCtl_q  <= rxo_outctl_t'(`RXO_OUTCTL_RESET);
         loopCtl_q <= rxo_loopctl_t'(`RXO_LOOPCTL_RESET);
      end else if (regWrEn) begin
         if (regAddr == `RXO_ADDR_OUTCTL) begin
            outCtl_q <= rxo_outctl_t'(regWrData);
         end
         if (regAddr == `RXO_ADDR_LOOPCTL) begin
            loopCtl_q <= rxo_loopctl_t'(regWrData);
         end
      end
   end

   // Register reads; unmapped addresses read zero
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         regRdData_q <= 5'h00;
      end else if (regRdEn) begin
         case (regAddr)
            `RXO_ADDR_STATUS: begin
               regRdData_q                    <= 5'h00;
               regRdData_q[`RXO_ST_LOSS]      <= statS[2];
               regRdData_q[`RXO_ST_AMPLITUDE] <= statS[1];
               regRdData_q[`RXO_ST_ZERO_RUN]  <= statS[0];
            end
            `RXO_ADDR_OUTCTL:  regRdData_q <= rxo_reg_t'(outCtl_q);
            `RXO_ADDR_LOOPCTL: regRdData_q <= rxo_reg_t'(loopCtl_q);
            default:           regRdData_q <= 5'h00;
         endcase
      end
   end

   // Host mode takes registers, hardware mode takes pins
   always_comb begin
      cfgS = '0;
      if (hostS) begin
         cfgS.loop          = rxo_loop_f(loopCtl_q.localLoopbackSel,
                                         loopCtl_q.remoteLoopbackSel);
         cfgS.e3Mode        = loopCtl_q.e3;
         cfgS.mute          = outCtl_q.muteOnDropoutBit;
         cfgS.singleRail    = outCtl_q.singleRailSelect;
         cfgS.clockAInvert  = outCtl_q.clockAInvert;
         cfgS.clockBInvert  = outCtl_q.clockBInvert;
         cfgS.clockBDisable = outCtl_q.clockBDisable;
         cfgS.transmit_driver_off         = 1'b0;
      end else begin
         cfgS.loop          = rxo_loop_f(pinS[3], pinS[2]);
         cfgS.e3Mode        = pinS[0];
         cfgS.mute          = pinS[5];
         cfgS.clockBInvert  = pinS[4];
         cfgS.transmit_driver_off         = pinS[1];
      end
   end

   // Loss status back from the link domain
   rxo_sync #(.W(3)) statSync (
      .clock (clock),
      .d     ({lossL_q, dropL}),
      .q     (statS)
   );

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         signalAbsent_q <= 1'b0;
      end else begin
         signalAbsent_q <= statS[2];
      end
   end

   // Link domain: reset, configuration and detector levels cross by two flops
   rxo_sync #(.W(1)) rstSync (
      .clock (recClk),
      .d     (rst_n),
      .q     (linkRstN)
   );

   rxo_sync #(.W($bits(rxo_cfg_t))) cfgSync (
      .clock (recClk),
      .d     (cfgS),
      .q     (cfgL)
   );

   rxo_sync #(.W(2)) dropSync (
      .clock (recClk),
      .d     ({amplitudeDropout, zeroRunDropout}),
      .q     (dropL)
   );

   // Line bit period is two link edges; data moves on the rising phase
   assign upd = !phase_q;

   always_ff @(posedge recClk) begin
      if (!linkRstN) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= ~phase_q;
      end
   end

   // E3 watches amplitude only
   assign lossRaw = cfgL.e3Mode ? dropL[1] : (dropL[1] | dropL[0]);

   always_ff @(posedge recClk) begin
      if (!linkRstN) begin
         lossL_q <= 1'b0;
      end else begin
         lossL_q <= lossRaw || cfgL.loop == RXO_LOOP_ANALOG
                    || cfgL.loop == RXO_LOOP_DIGITAL;
      end
   end

   // Receive source per loopback choice
   always_comb begin
      case (cfgL.loop)
         RXO_LOOP_NONE:    source = rxDecoded;
         RXO_LOOP_REMOTE:  source = rxDecoded;
         RXO_LOOP_ANALOG:  source = cfgL.transmit_driver_off ? '0 : txEncoded;
         RXO_LOOP_DIGITAL: source = txEncoded;
         default:          source = rxDecoded;
      endcase
   end

   // Muting holds even in local loopback, so the controller must clear it first
   assign muteNow = cfgL.mute && lossL_q;

   always_ff @(posedge recClk) begin
      if (!linkRstN) begin
         rxPlus_q  <= 1'b0;
         rxMinus_q <= 1'b0;
      end else if (upd) begin
         if (muteNow) begin
            rxPlus_q  <= 1'b0;
            rxMinus_q <= 1'b0;
         end else if (cfgL.singleRail) begin
            rxPlus_q  <= source.plus | source.minus;
            rxMinus_q <= 1'b0;
         end else begin
            rxPlus_q  <= source.plus;
            rxMinus_q <= source.minus;
         end
      end
   end

   // Clock outputs follow the phase; inversion touches only polarity
   always_ff @(posedge recClk) begin
      if (!linkRstN) begin
         recClkA_q <= 1'b0;
         recClkB_q <= 1'b0;
      end else begin
         recClkA_q <= ~phase_q ^ cfgL.clockAInvert;
         recClkB_q <= cfgL.clockBDisable ? 1'b0 : (~phase_q ^ cfgL.clockBInvert);
      end
   end

   // Line side: transmit data out, receive data in remote loopback
   always_ff @(posedge recClk) begin
      if (!linkRstN) begin
         lineTx_q <= '0;
      end else if (upd) begin
         if (cfgL.loop == RXO_LOOP_REMOTE) begin
            lineTx_q <= rxDecoded;
         end else if (cfgL.transmit_driver_off) begin
            lineTx_q <= '0;
         end else begin
            lineTx_q <= txEncoded;
         end
      end
   end

   assign regRdData        = regRdData_q;
   assign signalAbsentFlag = signalAbsent_q;
   assign rxPlusRailOut    = rxPlus_q;
   assign rxMinusRailOut   = rxMinus_q;
   assign recoveredClockA  = recClkA_q;
   assign recoveredClockB  = recClkB_q;
   assign lineTx           = lineTx_q;

   // Checks on the link side
   default clocking linkCk @(posedge recClk); endclocking
   default disable iff (!linkRstN);

   sequence mutedUpdate;
      upd && cfgL.mute && lossL_q;
   endsequence

   sequence analogTxOff;
      upd && cfgL.loop == RXO_LOOP_ANALOG && cfgL.transmit_driver_off && !cfgL.mute;
   endsequence

   sequence cleanDual;
      upd && !lossL_q && !cfgL.singleRail && cfgL.loop == RXO_LOOP_NONE;
   endsequence

   mute_zero_a: assert property (mutedUpdate |=> !rxPlus_q && !rxMinus_q)
      else $error("receive rails not muted during loss");

   resume_data_a: assert property (cleanDual |=> rxPlus_q == $past(rxDecoded.plus)
      && rxMinus_q == $past(rxDecoded.minus))
      else $error("line data not delivered after loss cleared");

   local_loss_a: assert property ((cfgL.loop == RXO_LOOP_ANALOG
      || cfgL.loop == RXO_LOOP_DIGITAL) |=> lossL_q)
      else $error("local loopback did not declare loss");

   data_edge_a: assert property (($changed(rxPlus_q) && !$past(cfgL.clockAInvert))
      |-> recClkA_q && !$past(recClkA_q))
      else $error("data changed off the rising clock edge");

   clock_rate_a: assert property ($stable(cfgL.clockAInvert)
      |=> $changed(recClkA_q))
      else $error("recovered clock not toggling each link edge");

   minus_low_a: assert property (upd && cfgL.singleRail && !muteNow
      |=> !rxMinus_q && rxPlus_q == ($past(source.plus) | $past(source.minus)))
      else $error("single rail format wrong");

   analog_off_a: assert property (analogTxOff |=> !rxPlus_q && !rxMinus_q)
      else $error("analog loopback passed data with transmit off");

   digital_path_a: assert property (upd && cfgL.loop == RXO_LOOP_DIGITAL
      && !cfgL.mute && !cfgL.singleRail |=> rxPlus_q == $past(txEncoded.plus)
      && rxMinus_q == $past(txEncoded.minus))
      else $error("digital loopback path broken");

   invert_phase_a: assert property ($past(cfgL.clockAInvert)
      |-> recClkA_q != phase_q)
      else $error("inverted clock phase wrong");

   // Checks on the system side
   host_mute_a: assert property (@(posedge clock) disable iff (!rst_n)
      regWrEn && regAddr == `RXO_ADDR_OUTCTL && hostS ##1 hostS
      |-> cfgS.mute == $past(regWrData[`RXO_OC_MUTE]))
      else $error("host mute bit not applied");

   pin_mute_a: assert property (@(posedge clock) disable iff (!rst_n)
      !hostS |-> cfgS.mute == pinS[5] && !cfgS.clockAInvert && !cfgS.singleRail)
      else $error("hardware mode configuration wrong");

   loop_map_a: assert property (@(posedge clock) disable iff (!rst_n)
      hostS && loopCtl_q.localLoopbackSel && !loopCtl_q.remoteLoopbackSel
      |-> cfgS.loop == RXO_LOOP_ANALOG)
      else $error("analog loopback not selected");

   status_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(statS[2]) |=> signalAbsent_q == $past(statS[2]))
      else $error("loss flag did not follow link loss");
endmodule

// file: verilog/rxo_consts.svh
// Purpose: Offsets, field positions, reset values and rates of the receive output block
// Assumes: Registers are 5 bits wide behind the serial host port
// Notes:   Definitions only
`ifndef RXO_CONSTS_SVH
`define RXO_CONSTS_SVH

`define RXO_ADDR_STATUS     8'h00
`define RXO_ADDR_OUTCTL     8'h03
`define RXO_ADDR_LOOPCTL    8'h04

`define RXO_OUTCTL_RESET    5'h00
`define RXO_LOOPCTL_RESET   5'h00

`define RXO_ST_LOSS         3
`define RXO_ST_AMPLITUDE    2
`define RXO_ST_ZERO_RUN     1

`define RXO_OC_SINGLE       4
`define RXO_OC_MUTE         3
`define RXO_OC_CLKB_DIS     2
`define RXO_OC_CLKB_INV     1
`define RXO_OC_CLKA_INV     0

`define RXO_LC_STS1_DS3     3
`define RXO_LC_E3           2
`define RXO_LC_LOCAL        1
`define RXO_LC_REMOTE       0

`define RXO_RATE_E3_KHZ     34368
`define RXO_RATE_DS3_KHZ    44736
`define RXO_RATE_STS1_KHZ   51840
`define RXO_LINK_PER_BIT    2

`endif

// file: verilog/rxo_pkg.sv
// Purpose: Types shared by the receive output block
// Assumes: Constants come from rxo_consts.svh
// Notes:   Register struct fields run from bit 4 down to bit 0
package rxo_pkg;

   typedef logic [4:0] rxo_reg_t;

   typedef struct packed {
      logic singleRailSelect;
      logic muteOnDropoutBit;
      logic clockBDisable;
      logic clockBInvert;
      logic clockAInvert;
   } rxo_outctl_t;

   typedef struct packed {
      logic spare;
      logic sts1Ds3;
      logic e3;
      logic localLoopbackSel;
      logic remoteLoopbackSel;
   } rxo_loopctl_t;

   typedef enum logic [1:0] {
      RXO_LOOP_NONE    = 2'b00,
      RXO_LOOP_REMOTE  = 2'b01,
      RXO_LOOP_ANALOG  = 2'b10,
      RXO_LOOP_DIGITAL = 2'b11
   } rxo_loop_t;

   typedef struct packed {
      logic plus;
      logic minus;
   } rxo_rail_t;

   typedef struct packed {
      rxo_loop_t loop;
      logic      e3Mode;
      logic      mute;
      logic      singleRail;
      logic      clockAInvert;
      logic      clockBInvert;
      logic      clockBDisable;
      logic      transmit_driver_off;
   } rxo_cfg_t;

   function automatic rxo_loop_t rxo_loop_f(input logic localSel, input logic remoteSel);
      rxo_loop_f = rxo_loop_t'({localSel, remoteSel});
   endfunction

endpackage

// file: verilog/rxo_sync.sv
// Purpose: Two-flop level synchroniser
// Assumes: Input is a level that holds for several destination clocks
// Notes:   No reset, so the chain settles after two edges
`timescale 1ns/1ps
module rxo_sync #(
   parameter int W = 1
) (
   // Clock
   input  wire logic         clock,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge clock) begin
      meta_q <= d;
      q      <= meta_q;
   end
endmodule

// file: test/rxo_term_model.sv
// Purpose: Line-side source and terminal-side sampler around the receive output block
// Assumes: Bench sets the line and transmit levels; they move on falling link edges only
// Notes:   Terminal samples on falling link edges, so it never races the rail update
`timescale 1ns/1ps
module rxo_term_model (
   // Link clock
   input  wire logic               recClk,
   // Levels chosen by the bench
   input  wire rxo_pkg::rxo_rail_t lineLevel,
   input  wire rxo_pkg::rxo_rail_t txLevel,
   // Toward the block
   output rxo_pkg::rxo_rail_t      rxDecoded,
   output rxo_pkg::rxo_rail_t      txEncoded,
   // From the block
   input  wire logic               railPlus,
   input  wire logic               railMinus,
   input  wire logic               clockA,
   // Observations
   output rxo_pkg::rxo_rail_t      seenRails,
   output int                      clockARises
);
   import rxo_pkg::*;

   initial begin
      rxDecoded = 2'h0;
      txEncoded = 2'h0;
      seenRails = 2'h0;
      clockARises = 0;
   end

   // Away from the block's sampling edge
   always @(negedge recClk) begin
      rxDecoded <= lineLevel;
      txEncoded <= txLevel;
   end

   // Falling link edge is away from the update edge whatever the clock polarity
   always @(negedge recClk) begin
      seenRails <= {railPlus, railMinus};
   end

   always @(posedge clockA) begin
      clockARises <= clockARises + 1;
   end
endmodule

// file: test/rxo_output_loop_ctrl_tb.sv
// Purpose: Register, muting, format, clock and loopback checks of the receive output block
// Assumes: Static line levels; each setting is given time to cross both domains
// Notes:   Fixed settle time covers pin sync, config sync and loss register
`timescale 1ns/1ps
`include "rxo_consts.svh"
module rxo_output_loop_ctrl_tb;
   import rxo_pkg::*;
   logic      clock, rst_n, recClk, regWrEn, regRdEn, hostMode, muteEnablePin;
   logic      clockBInvertPin, localLoopbackPin, remoteLoopbackPin, transmitDriverOffPin;
   logic      e3ModePin, amplitudeDropout, zeroRunDropout, signalAbsentFlag;
   logic      rxPlusRailOut, rxMinusRailOut, recoveredClockA, recoveredClockB;
   logic [7:0] regAddr;
   rxo_reg_t  regWrData, regRdData;
   rxo_rail_t rxDecoded, txEncoded, lineTx, lineLevel, txLevel, seenRails;
   int        clockARises, err_count, compares, n0;

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Phase unrelated to the system clock
   initial begin
      recClk = 1'b0;
      #7;
      forever #32 recClk = ~recClk;
   end

   rxo_output_loop_ctrl i_dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
      .hostMode(hostMode), .muteEnablePin(muteEnablePin), .clockBInvertPin(clockBInvertPin),
      .localLoopbackPin(localLoopbackPin), .remoteLoopbackPin(remoteLoopbackPin),
      .transmitDriverOffPin(transmitDriverOffPin), .e3ModePin(e3ModePin),
      .signalAbsentFlag(signalAbsentFlag), .recClk(recClk), .rxDecoded(rxDecoded),
      .txEncoded(txEncoded), .amplitudeDropout(amplitudeDropout),
      .zeroRunDropout(zeroRunDropout), .rxPlusRailOut(rxPlusRailOut),
      .rxMinusRailOut(rxMinusRailOut), .recoveredClockA(recoveredClockA),
      .recoveredClockB(recoveredClockB), .lineTx(lineTx));

   rxo_term_model i_term (.recClk(recClk), .lineLevel(lineLevel), .txLevel(txLevel),
      .rxDecoded(rxDecoded), .txEncoded(txEncoded), .railPlus(rxPlusRailOut),
      .railMinus(rxMinusRailOut), .clockA(recoveredClockA), .seenRails(seenRails),
      .clockARises(clockARises));

   task automatic check(input logic [4:0] seen, input logic [4:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("Compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input rxo_reg_t d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clock);
      regWrEn = 1'b0;
      @(negedge clock);
   endtask

   task automatic rd(input logic [7:0] a, input rxo_reg_t exp);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clock);
      regRdEn = 1'b0;
      @(negedge clock);
      check(regRdData, exp);
   endtask

   // Long enough for both synchroniser chains and the loss register
   task automatic settle;
      repeat (16) @(posedge recClk);
      @(negedge clock);
   endtask

   task automatic rails(input rxo_rail_t exp);
      check({3'h0, seenRails}, {3'h0, exp});
   endtask

   task automatic flag(input logic exp);
      check({4'h0, signalAbsentFlag}, {4'h0, exp});
   endtask

   task automatic clocksDiffer(input logic exp);
      check({4'h0, recoveredClockA ^ recoveredClockB}, {4'h0, exp});
   endtask

   // No wait is open-ended; this bounds the whole run
   initial begin
      repeat (40000) @(posedge clock);
      err_count++;
      conclude();
   end

   initial begin
      err_count = 0;
      compares = 0;
      rst_n = 1'b0;
      regAddr = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regWrData = 5'h00;
      hostMode = 1'b1;
      {muteEnablePin, clockBInvertPin, localLoopbackPin, remoteLoopbackPin} = 4'h0;
      {transmitDriverOffPin, e3ModePin, amplitudeDropout, zeroRunDropout} = 4'h0;
      lineLevel = 2'h0;
      txLevel = 2'h0;
      repeat (10) @(posedge clock);
      @(negedge clock);
      rst_n = 1'b1;
      rd(`RXO_ADDR_OUTCTL, `RXO_OUTCTL_RESET);
      rd(`RXO_ADDR_LOOPCTL, `RXO_LOOPCTL_RESET);
      rd(8'h05, 5'h00);
      wr(`RXO_ADDR_OUTCTL, 5'h1F);
      rd(`RXO_ADDR_OUTCTL, 5'h1F);
      wr(`RXO_ADDR_STATUS, 5'h1F);
      rd(`RXO_ADDR_STATUS, 5'h00);
      wr(`RXO_ADDR_OUTCTL, 5'h00);
      for (int p = 0; p < 4; p++) begin
         lineLevel = 2'(p);
         settle();
         rails(2'(p));
      end
      lineLevel = 2'b01;
      wr(`RXO_ADDR_OUTCTL, 5'h10);
      settle();
      rails(2'b10);
      lineLevel = 2'b10;
      wr(`RXO_ADDR_OUTCTL, 5'h08);
      amplitudeDropout = 1'b1;
      settle();
      rails(2'b00);
      flag(1'b1);
      rd(`RXO_ADDR_STATUS, 5'h0C);
      amplitudeDropout = 1'b0;
      zeroRunDropout = 1'b1;
      settle();
      rails(2'b00);
      rd(`RXO_ADDR_STATUS, 5'h0A);
      zeroRunDropout = 1'b0;
      settle();
      rails(2'b10);
      // Muting off before any local loopback
      wr(`RXO_ADDR_OUTCTL, 5'h00);
      amplitudeDropout = 1'b1;
      settle();
      rails(2'b10);
      amplitudeDropout = 1'b0;
      txLevel = 2'b01;
      wr(`RXO_ADDR_LOOPCTL, 5'h02);
      settle();
      flag(1'b1);
      rails(2'b01);
      check({3'h0, lineTx}, 5'h01);
      wr(`RXO_ADDR_LOOPCTL, 5'h03);
      settle();
      flag(1'b1);
      rails(2'b01);
      wr(`RXO_ADDR_LOOPCTL, 5'h01);
      settle();
      flag(1'b0);
      rails(2'b10);
      check({3'h0, lineTx}, 5'h02);
      wr(`RXO_ADDR_LOOPCTL, 5'h00);
      wr(`RXO_ADDR_OUTCTL, 5'h01);
      settle();
      clocksDiffer(1'b1);
      rails(2'b10);
      @(negedge recClk);
      n0 = clockARises;
      repeat (32) @(negedge recClk);
      check(5'(clockARises - n0), 5'h10);
      wr(`RXO_ADDR_OUTCTL, 5'h03);
      settle();
      clocksDiffer(1'b0);
      wr(`RXO_ADDR_OUTCTL, 5'h04);
      settle();
      repeat (2) begin
         @(negedge recClk);
         check({4'h0, recoveredClockB}, 5'h00);
      end
      wr(`RXO_ADDR_OUTCTL, 5'h00);
      hostMode = 1'b0;
      muteEnablePin = 1'b1;
      amplitudeDropout = 1'b1;
      settle();
      rails(2'b00);
      muteEnablePin = 1'b0;
      amplitudeDropout = 1'b0;
      e3ModePin = 1'b1;
      zeroRunDropout = 1'b1;
      settle();
      flag(1'b0);
      rails(2'b10);
      zeroRunDropout = 1'b0;
      e3ModePin = 1'b0;
      clockBInvertPin = 1'b1;
      settle();
      clocksDiffer(1'b1);
      localLoopbackPin = 1'b1;
      settle();
      flag(1'b1);
      rails(2'b01);
      // Analog loopback needs the driver on; digital does not
      transmitDriverOffPin = 1'b1;
      settle();
      rails(2'b00);
      remoteLoopbackPin = 1'b1;
      settle();
      rails(2'b01);
      conclude();
   end
endmodule
